// ==== msp_pkg.sv ====
// Purpose: constants and carrier types for the modem signal pin mux
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes:   function select codes per pin: 0 alternate, 1 chip select, else modem

package msp_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam int             MSP_AW       = 8;
   localparam logic [7:0]     MSP_OFS_SEL  = 8'h00;
   localparam logic [7:0]     MSP_OFS_MCR  = 8'h04;
   localparam logic [7:0]     MSP_OFS_MSR  = 8'h08;
   localparam logic [7:0]     MSP_OFS_IEN  = 8'h0C;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int             MSP_SEL_A_LSB  = 0;
   localparam int             MSP_SEL_B_LSB  = 2;
   localparam int             MSP_SEL_C_LSB  = 4;
   localparam int             MSP_MCR_DTR    = 0;
   localparam int             MSP_MCR_RTS    = 2;
   localparam int             MSP_MCR_LOOP   = 4;
   localparam int             MSP_MSR_DCHG   = 1;
   localparam int             MSP_MSR_DSR    = 5;
   localparam int             MSP_IEN_MS     = 0;

   // ----------------------------------------------------------------------
   // codes and reset values
   // ----------------------------------------------------------------------
   localparam logic [1:0]     MSP_FN_ALT      = 2'h0;
   localparam logic [1:0]     MSP_FN_CS       = 2'h1;
   localparam logic [1:0]     MSP_FN_MODEM    = 2'h2;
   localparam logic [5:0]     MSP_SEL_RST     = 6'h2A;
   localparam logic [4:0]     MSP_MCR_RST     = 5'h00;
   localparam logic           MSP_IEN_RST     = 1'h0;
   localparam logic [1:0]     MSP_RESP_OKAY   = 2'h0;
   localparam logic [1:0]     MSP_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // carriers between bus slave and register file
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic              en;
      logic [MSP_AW-1:0] addr;
      logic [31:0]       data;
      logic [3:0]        strb;
   } msp_wr_t;

   typedef struct packed {
      logic              en;
      logic [MSP_AW-1:0] addr;
   } msp_rd_t;

endpackage

// ==== msp_sync.sv ====
// Purpose: two flip-flop synchroniser for one pin input
// Assumes: pin idles high
// Notes:   only the second stage may be read

module msp_sync (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // pin and result
   input  wire logic d,
   output logic      q
);
   logic meta_ff;
   logic q_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= 1'h1;
         q_ff    <= 1'h1;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// ==== msp_axil.sv ====
// Purpose: AXI4-Lite slave front end for the pin mux registers
// Assumes: one write and one read outstanding at most
// Notes:   write strobe one cycle after both halves held; read answered next cycle

module msp_axil
   import msp_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // write channels
   input  wire logic [MSP_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // read channels
   input  wire logic [MSP_AW-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // register side
   output msp_wr_t                wr,
   input  wire logic              wr_ok,
   output msp_rd_t                rd,
   input  wire logic [31:0]       rd_data,
   input  wire logic              rd_ok
);
   logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]        bresp_ff, rresp_ff;
   logic [31:0]       rdata_ff, wdata_ff;
   logic [3:0]        wstrb_ff;
   logic [MSP_AW-1:0] waddr_ff;

   wire aw_hs   = awvalid & awready_ff;
   wire w_hs    = wvalid & wready_ff;
   wire b_hs    = bvalid_ff & bready;
   wire ar_hs   = arvalid & arready_ff;
   wire r_hs    = rvalid_ff & rready;
   wire both_in = ~awready_ff & ~wready_ff & ~bvalid_ff;

   assign wr = '{en: both_in, addr: waddr_ff, data: wdata_ff, strb: wstrb_ff};
   assign rd = '{en: ar_hs, addr: araddr};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'h1;
         wready_ff  <= 1'h1;
         bvalid_ff  <= 1'h0;
         bresp_ff   <= MSP_RESP_OKAY;
         waddr_ff   <= '0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
      end else begin
         if (aw_hs) begin
            awready_ff <= 1'h0;
            waddr_ff   <= awaddr;
         end
         if (w_hs) begin
            wready_ff <= 1'h0;
            wdata_ff  <= wdata;
            wstrb_ff  <= wstrb;
         end
         if (both_in) begin
            bvalid_ff <= 1'h1;
            bresp_ff  <= wr_ok ? MSP_RESP_OKAY : MSP_RESP_SLVERR;
         end else if (b_hs) begin
            bvalid_ff  <= 1'h0;
            awready_ff <= 1'h1;
            wready_ff  <= 1'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'h1;
         rvalid_ff  <= 1'h0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= MSP_RESP_OKAY;
      end else if (ar_hs) begin
         arready_ff <= 1'h0;
         rvalid_ff  <= 1'h1;
         rdata_ff   <= rd_data;
         rresp_ff   <= rd_ok ? MSP_RESP_OKAY : MSP_RESP_SLVERR;
      end else if (r_hs) begin
         arready_ff <= 1'h1;
         rvalid_ff  <= 1'h0;
      end
   end

   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;
endmodule

// ==== msp_top.sv ====
// Purpose: three shared pins carrying alternate, chip select or modem signals
// Assumes: internal sources on aclk; pin b input is asynchronous
// Notes:   registers over AXI4-Lite; all pin drivers registered
//
// Function
// - each pin carries one function, software-selected
// - pin a option one: bus request out
// - option two: chip selects six, seven, eight
// - pin c option one: shared memory drive
// - modem rts low when control bit two set
// - modem dtr low when control bit zero set
// - master reset sets rts, dtr inactive high
// - loop mode holds rts and dtr inactive
// - status bit five is inverse dsr pin
// - status bit one flags dsr change
// - dsr change raises enabled interrupt
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.

module msp_top
   import msp_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi write
   input  wire logic [MSP_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi read
   input  wire logic [MSP_AW-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // internal signal sources
   input  wire logic              aux_bus_request_n,
   input  wire logic              chip_select_six_n,
   input  wire logic              chip_select_seven_n,
   input  wire logic              chip_select_eight_n,
   input  wire logic              shared_mem_drive,
   // pin a: request, chip select six or rts
   output logic                   pin_a_out,
   // pin b: grant, chip select seven or dsr
   input  wire logic              pin_b_in,
   output logic                   pin_b_out,
   output logic                   pin_b_oe,
   // pin c: drive, chip select eight or dtr
   output logic                   pin_c_out,
   // internal results
   output logic                   aux_bus_grant_n,
   output logic                   modem_status_irq
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic msp_hit(input logic [MSP_AW-1:0] a, input logic [7:0] ofs);
      msp_hit = (a[MSP_AW-1:2] == ofs[MSP_AW-1:2]);
   endfunction

   function automatic logic [1:0] msp_fn(input logic [5:0] s, input int lsb);
      msp_fn = s[lsb +: 2];
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   msp_wr_t     wr;
   msp_rd_t     rd;
   logic [31:0] rd_data;
   logic        wr_ok, rd_ok;
   logic        dsr_pin_s;
   logic [5:0]  sel_ff;
   logic [4:0]  mcr_ff;
   logic        ien_ff;
   logic        dsr_bit_ff;
   logic        dsr_change_flag_ff;
   logic        irq_ff;
   logic        pin_a_ff, pin_b_out_ff, pin_b_oe_ff, pin_c_ff;
   logic        grant_n_ff;

   // ----------------------------------------------------------------------
   // bus slave and pin synchroniser
   // ----------------------------------------------------------------------
   msp_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr      (wr),
      .wr_ok   (wr_ok),
      .rd      (rd),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   msp_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pin_b_in),
      .q       (dsr_pin_s)
   );

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   wire hit_w_sel = msp_hit(wr.addr, MSP_OFS_SEL);
   wire hit_w_mcr = msp_hit(wr.addr, MSP_OFS_MCR);
   wire hit_w_msr = msp_hit(wr.addr, MSP_OFS_MSR);
   wire hit_w_ien = msp_hit(wr.addr, MSP_OFS_IEN);
   wire hit_r_sel = msp_hit(rd.addr, MSP_OFS_SEL);
   wire hit_r_mcr = msp_hit(rd.addr, MSP_OFS_MCR);
   wire hit_r_msr = msp_hit(rd.addr, MSP_OFS_MSR);
   wire hit_r_ien = msp_hit(rd.addr, MSP_OFS_IEN);
   wire lane0     = wr.en & wr.strb[0];

   // status register is read-only; its write is acknowledged and dropped
   assign wr_ok = hit_w_sel | hit_w_mcr | hit_w_msr | hit_w_ien;
   assign rd_ok = hit_r_sel | hit_r_mcr | hit_r_msr | hit_r_ien;

   wire [31:0] msr_word = (32'(dsr_bit_ff) << MSP_MSR_DSR) |
                          (32'(dsr_change_flag_ff) << MSP_MSR_DCHG);

   assign rd_data = hit_r_sel ? {26'h0, sel_ff} :
                    hit_r_mcr ? {27'h0, mcr_ff} :
                    hit_r_msr ? msr_word :
                    hit_r_ien ? {31'h0, ien_ff} : 32'h0;

   wire msr_rd = rd.en & hit_r_msr;

   // ----------------------------------------------------------------------
   // function selection
   // ----------------------------------------------------------------------
   wire [1:0] fn_a = msp_fn(sel_ff, MSP_SEL_A_LSB);
   wire [1:0] fn_b = msp_fn(sel_ff, MSP_SEL_B_LSB);
   wire [1:0] fn_c = msp_fn(sel_ff, MSP_SEL_C_LSB);
   wire       loop_on  = mcr_ff[MSP_MCR_LOOP];
   wire       modem_a  = (fn_a != MSP_FN_ALT) && (fn_a != MSP_FN_CS);
   wire       modem_b  = (fn_b != MSP_FN_ALT) && (fn_b != MSP_FN_CS);
   wire       modem_c  = (fn_c != MSP_FN_ALT) && (fn_c != MSP_FN_CS);

   // modem outputs, forced inactive in loop mode
   wire rts_n = ~(mcr_ff[MSP_MCR_RTS] & ~loop_on);
   wire dtr_n = ~(mcr_ff[MSP_MCR_DTR] & ~loop_on);

   wire nxt_pin_a = (fn_a == MSP_FN_ALT) ? aux_bus_request_n :
                    (fn_a == MSP_FN_CS)  ? chip_select_six_n : rts_n;
   wire nxt_pin_c = (fn_c == MSP_FN_ALT) ? shared_mem_drive :
                    (fn_c == MSP_FN_CS)  ? chip_select_eight_n : dtr_n;
   wire nxt_pin_b_oe = (fn_b == MSP_FN_CS);

   // grant reaches the inside only when pin b carries it
   wire nxt_grant_n = (fn_b == MSP_FN_ALT) ? dsr_pin_s : 1'h1;

   // ----------------------------------------------------------------------
   // modem status
   // ----------------------------------------------------------------------
   // in loop mode dsr follows the dtr control bit instead of the pin
   wire dsr_src     = loop_on ? mcr_ff[MSP_MCR_DTR] : ~dsr_pin_s;
   wire dsr_upd     = modem_b | loop_on;
   wire nxt_dsr_bit = dsr_upd ? dsr_src : dsr_bit_ff;
   wire dsr_chg     = nxt_dsr_bit != dsr_bit_ff;
   // a change in the read cycle wins over the clear
   wire nxt_dsr_change_flag = dsr_chg | (dsr_change_flag_ff & ~msr_rd);
   wire nxt_irq = ien_ff & dsr_change_flag_ff;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_ff <= MSP_SEL_RST;
         mcr_ff <= MSP_MCR_RST;
         ien_ff <= MSP_IEN_RST;
      end else if (lane0) begin
         if (hit_w_sel)
            sel_ff <= wr.data[5:0];
         if (hit_w_mcr)
            mcr_ff <= wr.data[4:0];
         if (hit_w_ien)
            ien_ff <= wr.data[MSP_IEN_MS];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dsr_bit_ff         <= 1'h0;
         dsr_change_flag_ff <= 1'h0;
         irq_ff             <= 1'h0;
      end else begin
         dsr_bit_ff         <= nxt_dsr_bit;
         dsr_change_flag_ff <= nxt_dsr_change_flag;
         irq_ff             <= nxt_irq;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_a_ff     <= 1'h1;
         pin_b_out_ff <= 1'h1;
         pin_b_oe_ff  <= 1'h0;
         pin_c_ff     <= 1'h1;
         grant_n_ff   <= 1'h1;
      end else begin
         pin_a_ff     <= nxt_pin_a;
         pin_b_out_ff <= chip_select_seven_n;
         pin_b_oe_ff  <= nxt_pin_b_oe;
         pin_c_ff     <= nxt_pin_c;
         grant_n_ff   <= nxt_grant_n;
      end
   end

   assign pin_a_out        = pin_a_ff;
   assign pin_b_out        = pin_b_out_ff;
   assign pin_b_oe         = pin_b_oe_ff;
   assign pin_c_out        = pin_c_ff;
   assign aux_bus_grant_n  = grant_n_ff;
   assign modem_status_irq = irq_ff;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_rts_on;
      modem_a && mcr_ff[MSP_MCR_RTS] && !loop_on;
   endsequence

   sequence s_dtr_on;
      modem_c && mcr_ff[MSP_MCR_DTR] && !loop_on;
   endsequence

   sequence s_dsr_edge;
      dsr_chg;
   endsequence

   sequence s_flag_then_irq;
      dsr_change_flag_ff ##1 modem_status_irq;
   endsequence

   property p_rts_low;
      @(posedge aclk) disable iff (!aresetn)
      s_rts_on |=> !pin_a_out;
   endproperty
   a_rts_low: assert property (p_rts_low)
      else $error("rts pin not low with rts bit set");

   property p_dtr_low;
      @(posedge aclk) disable iff (!aresetn)
      s_dtr_on |=> !pin_c_out;
   endproperty
   a_dtr_low: assert property (p_dtr_low)
      else $error("dtr pin not low with dtr bit set");

   property p_reset_idle;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> pin_a_out && pin_c_out && !pin_b_oe;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins not idle after reset");

   property p_loop_idle;
      @(posedge aclk) disable iff (!aresetn)
      (loop_on && modem_a && modem_c) |=> pin_a_out && pin_c_out;
   endproperty
   a_loop_idle: assert property (p_loop_idle)
      else $error("loop mode did not hold rts and dtr high");

   property p_dsr_inverse;
      @(posedge aclk) disable iff (!aresetn)
      (modem_b && !loop_on) |=> dsr_bit_ff == !$past(dsr_pin_s);
   endproperty
   a_dsr_inverse: assert property (p_dsr_inverse)
      else $error("dsr status not inverse of pin");

   property p_change_sets;
      @(posedge aclk) disable iff (!aresetn)
      s_dsr_edge |=> dsr_change_flag_ff;
   endproperty
   a_change_sets: assert property (p_change_sets)
      else $error("dsr change flag not set");

   property p_irq_follows;
      @(posedge aclk) disable iff (!aresetn)
      (ien_ff && dsr_change_flag_ff && $stable(ien_ff)) |-> ##1 modem_status_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("enabled dsr change gave no interrupt");

   property p_irq_cause;
      @(posedge aclk) disable iff (!aresetn)
      modem_status_irq |-> $past(ien_ff) && $past(dsr_change_flag_ff);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without enabled change flag");

   property p_read_clears;
      @(posedge aclk) disable iff (!aresetn)
      (msr_rd && !dsr_chg) |=> !dsr_change_flag_ff;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status read did not clear change flag");

   property p_oe_cs_only;
      @(posedge aclk) disable iff (!aresetn)
      pin_b_oe |-> $past(fn_b) == MSP_FN_CS;
   endproperty
   a_oe_cs_only: assert property (p_oe_cs_only)
      else $error("pin b driven outside chip select option");

   property p_cs_follow;
      @(posedge aclk) disable iff (!aresetn)
      (fn_a == MSP_FN_CS) |=> pin_a_out == $past(chip_select_six_n);
   endproperty
   a_cs_follow: assert property (p_cs_follow)
      else $error("pin a does not follow chip select six");

   property p_req_follow;
      @(posedge aclk) disable iff (!aresetn)
      (fn_a == MSP_FN_ALT) |=> pin_a_out == $past(aux_bus_request_n);
   endproperty
   a_req_follow: assert property (p_req_follow)
      else $error("pin a does not follow bus request");

   property p_drive_follow;
      @(posedge aclk) disable iff (!aresetn)
      (fn_c == MSP_FN_ALT) |=> pin_c_out == $past(shared_mem_drive);
   endproperty
   a_drive_follow: assert property (p_drive_follow)
      else $error("pin c does not follow shared memory drive");

   property p_grant_only_alt;
      @(posedge aclk) disable iff (!aresetn)
      !aux_bus_grant_n |-> $past(fn_b) == MSP_FN_ALT;
   endproperty
   a_grant_only_alt: assert property (p_grant_only_alt)
      else $error("grant seen while pin b has another function");

endmodule

// ==== msp_partner.sv ====
// Purpose: far side of pin b: auxiliary processor grant or modem dsr
// Assumes: bench selects which party stands on pin b
// Notes:   grant follows the request after one or three cycles

module msp_partner (
   // clock
   input  wire logic aclk,
   // pins
   input  wire logic pin_a_out,
   input  wire logic pin_b_out,
   input  wire logic pin_b_oe,
   output logic      pin_b_wire,
   // bench control
   input  wire logic aux_mode,
   input  wire logic slow,
   input  wire logic dsr_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // grant and wire level
   // ----------------------------------------------------------------------
   logic [2:0] req_ff;
   logic       grant_n;
   always_ff @(posedge aclk) begin
      req_ff <= {req_ff[1:0], pin_a_out};
   end
   assign grant_n    = slow ? req_ff[2] : req_ff[0];
   assign pin_b_wire = pin_b_oe ? pin_b_out : (aux_mode ? grant_n : dsr_n);
endmodule

// ==== msp_tb_top.sv ====
// Purpose: self-checking bench for the modem signal pin mux
// Assumes: partner model stands on pin b
// Notes:   sources drawn from an xorshift with a fixed seed

module msp_tb_top
   import msp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              aclk = 1'h0;
   logic              aresetn = 1'h0;
   logic [MSP_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]       wdata = 32'h0, rdata, v, m;
   logic [3:0]        wstrb = 4'h0;
   logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic              arvalid = 1'h0, rready = 1'h0;
   logic              aux_bus_request_n = 1'h1, chip_select_six_n = 1'h1;
   logic              chip_select_seven_n = 1'h1, chip_select_eight_n = 1'h1;
   logic              shared_mem_drive = 1'h0;
   logic              aux_mode = 1'h0, slow = 1'h0, dsr_n = 1'h1;
   logic              awready, wready, bvalid, arready, rvalid, pin_a_out, pin_b_in;
   logic              pin_b_out, pin_b_oe, pin_c_out, aux_bus_grant_n, modem_status_irq;
   logic [1:0]        bresp, rresp, r, c;
   logic [31:0]       seed = 32'h0000C1CF;
   int                n_mismatch = 0, cmp_count = 0;

   msp_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .aux_bus_request_n, .chip_select_six_n, .chip_select_seven_n,
      .chip_select_eight_n, .shared_mem_drive, .pin_a_out, .pin_b_in, .pin_b_out,
      .pin_b_oe, .pin_c_out, .aux_bus_grant_n, .modem_status_irq);
   msp_partner u_far (.aclk, .pin_a_out, .pin_b_out, .pin_b_oe, .pin_b_wire(pin_b_in),
      .aux_mode, .slow, .dsr_n);

   initial begin
      forever #4 aclk = ~aclk;
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic pick(input logic [1:0] k, input logic s0, s1, md);
      return (k == MSP_FN_ALT) ? s0 : ((k == MSP_FN_CS) ? s1 : md);
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic hang();
      $display("Error handshake expected 1 seen 0");
      n_mismatch++;
      give_verdict();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
            break;
      end
      s = bresp;
      bready <= 1'h0;
      if (n == 40)
         hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
            break;
      end
      d = rdata;
      s = rresp;
      rready <= 1'h0;
      if (n == 40)
         hang();
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  s;
      rd(a, d, s);
      chk("rdata", e, d);
      chk("rresp", {30'h0, MSP_RESP_OKAY}, s);
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      chk("pin_a_out", 32'h1, pin_a_out);
      chk("pin_c_out", 32'h1, pin_c_out);
      chk("pin_b_oe", 32'h0, pin_b_oe);
      aresetn <= 1'h1;
      rdc(MSP_OFS_SEL, 32'h2A);
      rdc(MSP_OFS_MCR, 32'h0);
      rdc(MSP_OFS_IEN, 32'h0);
      for (int i = 0; i < 8; i++) begin
         m = (i == 0) ? 32'h5 : (xs() & 32'h1F);
         wr(MSP_OFS_MCR, m, r);
         chk("bresp", {30'h0, MSP_RESP_OKAY}, r);
         repeat (2) @(posedge aclk);
         chk("pin_a_out", {31'h0, m[4] | ~m[2]}, pin_a_out);
         chk("pin_c_out", {31'h0, m[4] | ~m[0]}, pin_c_out);
         rdc(MSP_OFS_MCR, m);
      end
      wr(MSP_OFS_IEN, 32'h1, r);
      wr(MSP_OFS_MCR, 32'h0, r);
      repeat (6) @(posedge aclk);
      rd(MSP_OFS_MSR, v, r);
      dsr_n <= 1'h0;
      repeat (6) @(posedge aclk);
      chk("irq", 32'h1, modem_status_irq);
      rdc(MSP_OFS_MSR, 32'h22);
      rdc(MSP_OFS_MSR, 32'h20);
      chk("irq", 32'h0, modem_status_irq);
      dsr_n <= 1'h1;
      repeat (6) @(posedge aclk);
      rdc(MSP_OFS_MSR, 32'h02);
      wr(MSP_OFS_IEN, 32'h0, r);
      dsr_n <= 1'h0;
      repeat (6) @(posedge aclk);
      chk("irq", 32'h0, modem_status_irq);
      rdc(MSP_OFS_MSR, 32'h22);
      wr(MSP_OFS_MSR, 32'h0, r);
      chk("bresp", {30'h0, MSP_RESP_OKAY}, r);
      rdc(MSP_OFS_MSR, 32'h20);
      for (int i = 0; i < 12; i++) begin
         c = i[1:0];
         aux_mode <= (c == MSP_FN_ALT);
         slow <= i[2];
         wr(MSP_OFS_SEL, {26'h0, c, c, c}, r);
         v = xs();
         {aux_bus_request_n, chip_select_six_n, chip_select_seven_n, chip_select_eight_n,
            shared_mem_drive} <= v[4:0];
         repeat (10) @(posedge aclk);
         m[0] = pick(c, aux_bus_request_n, chip_select_six_n, 1'h1);
         m[1] = pick(c, shared_mem_drive, chip_select_eight_n, 1'h1);
         chk("pin_a_out", {31'h0, m[0]}, pin_a_out);
         chk("pin_c_out", {31'h0, m[1]}, pin_c_out);
         chk("pin_b_oe", {31'h0, c == MSP_FN_CS}, pin_b_oe);
         if (c == MSP_FN_CS)
            chk("pin_b_out", {31'h0, chip_select_seven_n}, pin_b_out);
         chk("grant", {31'h0, pick(c, aux_bus_request_n, 1'h1, 1'h1)}, aux_bus_grant_n);
      end
      wr(MSP_OFS_SEL, 32'h2A, r);
      wr(MSP_OFS_MCR, 32'h5, r);
      repeat (2) @(posedge aclk);
      chk("pin_a_out", 32'h0, pin_a_out);
      chk("pin_c_out", 32'h0, pin_c_out);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      chk("pin_a_out", 32'h1, pin_a_out);
      chk("pin_c_out", 32'h1, pin_c_out);
      aresetn <= 1'h1;
      rdc(MSP_OFS_MCR, 32'h0);
      wr(8'h10, xs(), r);
      chk("bresp", {30'h0, MSP_RESP_SLVERR}, r);
      rd(8'h10, v, r);
      chk("rresp", {30'h0, MSP_RESP_SLVERR}, r);
      chk("rdata", 32'h0, v);
      give_verdict();
   end
endmodule
